// *** rtl/sslld_core.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Each rising serial clock edge shifts the register one place, taking serial input.
// RULE2: Serial input enters at the first stage of the shift register.
// RULE3: Last shift stage appears on the serial output for cascading.
// RULE4: While latch strobe is high, shift bits are copied into latch bits.
// RULE5: Latches follow every new shift value while the strobe stays high; the code only takes a shift word once it has settled across the crossing.
// RULE6: With strobe low, latches hold their values whatever shifting occurs.
// RULE7: With strobe tied high, the host keeps blanking high during data entry.
// RULE8: Blanking input high turns all sixteen sink drivers off.
// RULE9: Blanking never alters latch contents.
// RULE10: Blanking low lets each sink follow its own latch bit.
// RULE11: Sixteen sink outputs, each driven by exactly one latch bit.
// RULE12: Serial output changes only on rising serial clock edges.
module sslld_core #(
    parameter int WIDTH = sslld_pkg::SSLLD_WIDTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic blank_n_off,
    output logic serial_out,
    output logic [WIDTH-1:0] sink_outputs
);
    import sslld_pkg::*;

    // ************************************************************
    // Link domain: shift register on the serial clock
    // ************************************************************
    // The serial clock may stop between frames; nothing here relies on free running.
    // The link reset flag only gates the link checks, because the register itself
    // is cleared directly by the asynchronous reset and must shift from the first edge.
    // A host that clocks right at reset release may lose that one bit; this is accepted.
    logic [WIDTH-1:0] shift_r;
    logic link_rst_s1_r;
    logic link_rst_n_r;

    always_ff @(posedge shift_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_rst_s1_r <= SSLLD_LINK_HOLD;
            link_rst_n_r <= SSLLD_LINK_HOLD;
        end else begin
            link_rst_s1_r <= SSLLD_LINK_GO;
            link_rst_n_r <= link_rst_s1_r;
        end
    end

    always_ff @(posedge shift_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r <= WIDTH'(SSLLD_REG_RST);
        end else begin
            shift_r <= {shift_r[WIDTH-2:0], serial_in}; // RULE1 RULE2
        end
    end

    assign serial_out = shift_r[WIDTH-1]; // RULE3 RULE12

    // ************************************************************
    // Crossing into the system clock domain
    // ************************************************************
    // The shift word is only sampled once it has been stable for two system edges,
    // so a word caught mid-shift never reaches the latches.
    // The price is latency: a new word reaches the latches some four system clocks
    // after the last link edge. A host that shifts without pause never gets a stable
    // word, so the latches only follow once the link goes quiet.
    logic [WIDTH-1:0] word_s1_r;
    logic [WIDTH-1:0] word_s2_r;
    logic [WIDTH-1:0] word_s3_r;
    logic strobe_s1_r;
    logic strobe_r;
    logic blank_s1_r;
    logic blank_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            word_s1_r <= WIDTH'(SSLLD_REG_RST);
            word_s2_r <= WIDTH'(SSLLD_REG_RST);
            word_s3_r <= WIDTH'(SSLLD_REG_RST);
        end else begin
            word_s1_r <= shift_r;
            word_s2_r <= word_s1_r;
            word_s3_r <= word_s2_r;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_s1_r <= SSLLD_BIT_RST;
            strobe_r <= SSLLD_BIT_RST;
            blank_s1_r <= SSLLD_BLANK_RST;
            blank_r <= SSLLD_BLANK_RST;
        end else begin
            strobe_s1_r <= latch_strobe;
            strobe_r <= strobe_s1_r;
            blank_s1_r <= blank_n_off;
            blank_r <= blank_s1_r;
        end
    end

    // ************************************************************
    // Latches and sink drivers
    // ************************************************************
    logic [WIDTH-1:0] latch_r;
    logic word_stable;

    assign word_stable = (word_s2_r == word_s3_r);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latch_r <= WIDTH'(SSLLD_REG_RST);
        end else if (strobe_r && word_stable) begin
            latch_r <= word_s3_r; // RULE4 RULE5
        end
    end
    // With strobe low the latch keeps its value; blanking is not an input here. RULE6 RULE9

    // ************************************************************
    // Sink drive decode
    // ************************************************************
    // Blanking wins over the latch, so a display can be dimmed by pulsing it
    // without disturbing the stored pattern.
    function automatic logic [WIDTH-1:0] sink_drive(
        input logic blank,
        input logic [WIDTH-1:0] latched
    );
        if (blank) begin
            return {WIDTH{SSLLD_SINK_OFF}}; // RULE8
        end
        return latched; // RULE10 RULE11
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sink_outputs <= {WIDTH{SSLLD_SINK_OFF}};
        end else begin
            sink_outputs <= sink_drive(blank_r, latch_r); // RULE8 RULE10 RULE11
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Link checks only start once the link reset flag is up, two link edges after release.

    // Serial input must land in the first stage one link edge later.
    chk_shift_moves_in: assert property (@(posedge shift_clk) disable iff (!reset_n) // RULE2
        link_rst_n_r |=> shift_r[0] == $past(serial_in))
        else $error("Serial input did not enter the first stage.");

    // Every other stage takes the value of the stage before it.
    chk_shift_one_place: assert property (@(posedge shift_clk) disable iff (!reset_n) // RULE1
        link_rst_n_r |=> shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]))
        else $error("Shift register did not move by one place.");

    // The cascade output carries what was one stage short of the end before the edge.
    chk_serial_out_tail: assert property (@(posedge shift_clk) disable iff (!reset_n) // RULE3
        link_rst_n_r |=> serial_out == $past(shift_r[WIDTH-2]))
        else $error("Serial output is not the last stage.");

    // The link reset flag must never rise ahead of its first stage.
    chk_link_sync_order: assert property (@(posedge shift_clk) disable iff (!reset_n) // RULE1
        link_rst_n_r |-> link_rst_s1_r)
        else $error("Link reset released out of order.");

    // Seen from the system clock, the cascade output only moves with the register.
    chk_serial_out_edge: assert property (@(posedge mclk) disable iff (!reset_n) // RULE12
        $changed(serial_out) |-> $changed(shift_r))
        else $error("Serial output changed without a shift.");

    // A stable word with the strobe up is taken on the next system edge.
    chk_latch_follows: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
        (strobe_r && word_stable) |=> latch_r == $past(word_s3_r))
        else $error("Latch did not take the shift word.");

    // With the strobe held, the latch keeps taking each settled word.
    chk_latch_transparent: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
        (strobe_r && word_stable)[*2] |=> latch_r == $past(word_s3_r))
        else $error("Latch stopped following while strobe high.");

    // A word still moving across the crossing must not reach the latch.
    chk_word_unsettled: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
        (strobe_r && !word_stable) |=> $stable(latch_r))
        else $error("Latch took an unsettled word.");

    // With the strobe low, shifting must not reach the latch.
    chk_latch_holds: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
        !strobe_r |=> $stable(latch_r))
        else $error("Latch changed with strobe low.");

    // Toggling the blanking input alone leaves the latch untouched.
    chk_blank_keeps_latch: assert property (@(posedge mclk) disable iff (!reset_n) // RULE9
        ($changed(blank_r) && !strobe_r) |=> $stable(latch_r))
        else $error("Blanking disturbed the latch.");

    // Blanking forces every sink off.
    chk_blank_off: assert property (@(posedge mclk) disable iff (!reset_n) // RULE8
        blank_r |=> sink_outputs == {WIDTH{SSLLD_SINK_OFF}})
        else $error("Sinks on while blanked.");

    // Unblanked sinks show the latch.
    chk_sink_follow: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
        !blank_r |=> sink_outputs == $past(latch_r))
        else $error("Sinks do not follow latches.");

    // Lifting the blanking brings back exactly the stored pattern.
    chk_unblank_restore: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
        $fell(blank_r) |=> sink_outputs == $past(latch_r))
        else $error("Sinks wrong after blanking ends.");

    // No sink may be on unless its own latch bit is on.
    chk_sink_own_bit: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
        (sink_outputs & ~$past(latch_r)) == {WIDTH{SSLLD_SINK_OFF}})
        else $error("A sink is on without its latch bit.");

    // Any sink on means blanking was low one edge earlier.
    chk_sink_needs_enable: assert property (@(posedge mclk) disable iff (!reset_n) // RULE8
        (|sink_outputs) |-> !$past(blank_r))
        else $error("A sink is on although blanking was high.");
endmodule // sslld_core

// *** common/sslld_pkg.sv ***
package sslld_pkg;
    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int SSLLD_WIDTH = 16;
    localparam logic [SSLLD_WIDTH-1:0] SSLLD_REG_RST = 16'h0000;
    localparam logic SSLLD_BIT_RST = 1'b0;
    localparam logic SSLLD_SINK_OFF = 1'b0;
    localparam logic SSLLD_BLANK_RST = 1'b1;
    localparam logic SSLLD_LINK_HOLD = 1'b0;
    localparam logic SSLLD_LINK_GO = 1'b1;
endpackage

// *** bench/sslld_host_model.sv ***
`timescale 1ns/1ps
module sslld_host_model (
    output logic shift_clk,
    output logic serial_in
);
    initial begin
        shift_clk = 1'b0;
        serial_in = 1'b0;
    end
    // The link clock runs only inside a frame, and the first bit sent ends in the top sink.
    task automatic send(input logic [15:0] word, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = word[i];
            #16 shift_clk = 1'b1;
            #16 shift_clk = 1'b0;
        end
        serial_in = ~serial_in;
    endtask
endmodule // sslld_host_model

// *** bench/sslld_core_bench.sv ***
`timescale 1ns/1ps
module sslld_core_bench;
    import sslld_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic latch_strobe = 1'b0;
    logic blank_n_off = 1'b0;
    logic shift_clk;
    logic serial_in;
    logic serial_out;
    logic [SSLLD_WIDTH-1:0] sink_outputs;
    int bad_count = 0;
    int n_tests = 0;
    always #25 mclk = ~mclk;
    sslld_host_model host (.shift_clk(shift_clk), .serial_in(serial_in));
    sslld_core uut (.mclk(mclk), .reset_n(reset_n), .shift_clk(shift_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe), .blank_n_off(blank_n_off),
        .serial_out(serial_out), .sink_outputs(sink_outputs));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic check(input logic [SSLLD_WIDTH-1:0] exp, input logic so);
        n_tests++;
        if (sink_outputs !== exp || serial_out !== so) begin
            bad_count++;
            $display("[FAIL] %0t sinks %h out %b exp %h %b", $time, sink_outputs, serial_out, exp, so);
        end
    endtask
    task automatic t_capture;
        host.send(16'hA5C3, 16);
        step(3);
        check(16'h0000, 1'b1);
        latch_strobe = 1'b1;
        step(10);
        check(16'hA5C3, 1'b1);
    endtask
    task automatic t_follow;
        blank_n_off = 1'b1;
        host.send(16'h5A3C, 16);
        step(4);
        check(16'h0000, 1'b0);
        blank_n_off = 1'b0;
        step(10);
        check(16'h5A3C, 1'b0);
    endtask
    task automatic t_hold;
        latch_strobe = 1'b0;
        step(4);
        host.send(16'hFFFF, 16);
        step(10);
        check(16'h5A3C, 1'b1);
        blank_n_off = 1'b1;
        step(4);
        check(16'h0000, 1'b1);
        blank_n_off = 1'b0;
        step(4);
        check(16'h5A3C, 1'b1);
        host.send(16'h0000, 1);
        step(1);
        latch_strobe = 1'b1;
        step(10);
        check(16'hFFFE, 1'b1);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Link edges during reset and just after it are only there to settle the link reset.
    initial begin
        fork
            host.send(16'h0000, 4);
        join_none
        step(8);
        reset_n = 1'b1;
        host.send(16'h0000, 3);
        step(2);
        t_capture();
        t_follow();
        t_hold();
        report_and_stop();
    end
    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end
endmodule // sslld_core_bench
